/* File: sbc_regs.vh */
// Constants of the buffered SPI core: reset values, prescaler codes, timing
// Assumes inclusion by bare name from the core only; its receive buffer does not include it
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SBC_SHIFT_RST   8'h00
`define SBC_EMPTY_RST   1'b1
`define SBC_MASTER_RST  1'b0

// ----------------------------------------------------------------------------
// Prescaler codes and half periods of the generated clock, in ref_clk cycles
// ----------------------------------------------------------------------------
`define SBC_PRESC_DIV4   2'h0
`define SBC_PRESC_DIV16  2'h1
`define SBC_PRESC_DIV64  2'h2
`define SBC_PRESC_DIV128 2'h3
`define SBC_HALF_DIV4    7'h02
`define SBC_HALF_DIV16   7'h08
`define SBC_HALF_DIV64   7'h20
`define SBC_HALF_DIV128  7'h40

// ----------------------------------------------------------------------------
// Field positions of the clock mode, counts
// ----------------------------------------------------------------------------
`define SBC_MODE_PHASE   0
`define SBC_MODE_POLAR   1
`define SBC_BITS_BYTE    4'h8
`define SBC_EDGES_BYTE   5'h10
`define SBC_SLAVE_MIN_PHASE_CYC 2

`endif

/* File: sbc_rx_fifo.v */
// Two-entry receive buffer with valid and ready on both sides
// Assumes one clock, synchronous active-low reset, and a push only when ready
`timescale 1ns/1ps

module sbc_rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             ref_clk,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // --------------------------------------------------------------------------
  // Pointers wrap at DEPTH so any depth works, not just powers of two
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

/* File: sbc_core.v */
// SPI master/slave core with normal and buffered transfer handling
// Assumes pins arrive asynchronous; all control bits are plain levels
`timescale 1ns/1ps
`include "sbc_regs.vh"

module sbc_core #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk,
  input  wire             reset_n,
  input  wire             spi_enable,
  input  wire             master_write,
  input  wire             master_wdata,
  output wire             master_mode,
  input  wire             buffer_mode_enable,
  input  wire             buffer_wait_receive,
  input  wire             select_disable_bit,
  input  wire             ss_is_input,
  input  wire             miso_dir_out,
  input  wire             lsb_first,
  input  wire [1:0]       clock_mode,
  input  wire [1:0]       prescale,
  input  wire             clock_double,
  input  wire             transfer_irq_enable,
  input  wire             transfer_complete_irq_enable,
  input  wire             receive_complete_irq_enable,
  input  wire             buffer_empty_irq_enable,
  input  wire             clear_transfer_flag,
  input  wire             clear_write_collision,
  input  wire             clear_transfer_complete,
  input  wire             data_write,
  input  wire [WIDTH-1:0] data_wdata,
  output wire             rx_valid,
  input  wire             rx_ready,
  output wire [WIDTH-1:0] rx_data,
  output wire             transfer_flag,
  output wire             write_collision_flag,
  output wire             buffer_empty_flag,
  output wire             receive_complete_flag,
  output wire             transfer_complete_flag,
  output wire             irq,
  input  wire             sck_in,
  output wire             sck_out,
  output wire             sck_oe_n,
  input  wire             mosi_in,
  output wire             mosi_out,
  output wire             mosi_oe_n,
  input  wire             miso_in,
  output wire             miso_out,
  output wire             miso_oe_n,
  input  wire             ss_n_in
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function [6:0] half_period;
    input [1:0] presc;
    input       dbl;
    reg   [6:0] h;
    begin
      h = `SBC_HALF_DIV128;
      case (presc)
        `SBC_PRESC_DIV4:  h = `SBC_HALF_DIV4;
        `SBC_PRESC_DIV16: h = `SBC_HALF_DIV16;
        `SBC_PRESC_DIV64: h = `SBC_HALF_DIV64;
        default:          h = `SBC_HALF_DIV128;
      endcase
      half_period = dbl ? {1'b0, h[6:1]} : h;
    end
  endfunction

  function first_bit;
    input [WIDTH-1:0] v;
    input             lsb;
    begin
      first_bit = lsb ? v[0] : v[WIDTH-1];
    end
  endfunction

  function [WIDTH-1:0] shift_in;
    input [WIDTH-1:0] v;
    input             b;
    input             lsb;
    begin
      shift_in = lsb ? {b, v[WIDTH-1:1]} : {v[WIDTH-2:0], b};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  // --------------------------------------------------------------------------
  reg [2:0] sck_s_q;
  reg [2:0] ss_s_q;
  reg [2:0] mosi_s_q;
  reg [2:0] miso_s_q;
  reg       sck_f_q;
  reg       ss_f_q;
  reg       mosi_f_q;
  reg       miso_f_q;
  wire      sck_f_d;
  wire      ss_f_d;

  assign sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
  assign ss_f_d  = (ss_s_q[1] == ss_s_q[2]) ? ss_s_q[2] : ss_f_q;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sck_s_q  <= 3'h0;
      ss_s_q   <= 3'h7;
      mosi_s_q <= 3'h0;
      miso_s_q <= 3'h0;
      sck_f_q  <= 1'b0;
      ss_f_q   <= 1'b1;
      mosi_f_q <= 1'b0;
      miso_f_q <= 1'b0;
    end else begin
      sck_s_q  <= {sck_s_q[1:0], sck_in};
      ss_s_q   <= {ss_s_q[1:0], ss_n_in};
      mosi_s_q <= {mosi_s_q[1:0], mosi_in};
      miso_s_q <= {miso_s_q[1:0], miso_in};
      sck_f_q  <= sck_f_d;
      ss_f_q   <= ss_f_d;
      if (mosi_s_q[1] == mosi_s_q[2]) begin
        mosi_f_q <= mosi_s_q[2];
      end
      if (miso_s_q[1] == miso_s_q[2]) begin
        miso_f_q <= miso_s_q[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [WIDTH-1:0] sh_q;
  reg [WIDTH-1:0] txb_q;
  reg             txb_full_q;
  reg             sh_fresh_q;
  reg             tx_bit_q;
  reg [3:0]       bit_cnt_q;
  reg             master_q;
  reg             busy_q;
  reg             pend_q;
  reg [6:0]       div_q;
  reg [4:0]       edge_q;
  reg             sck_q;
  reg             if_q;
  reg             write_collision_flag_q;
  reg             dre_q;
  reg             rxc_q;
  reg             txc_q;
  reg             dre_rise_q;
  reg             rxc_step_q;
  reg             all_sent_q;
  reg             all_sent2_q;

  wire cpha     = clock_mode[`SBC_MODE_PHASE];
  wire cpol     = clock_mode[`SBC_MODE_POLAR];
  wire is_slave = spi_enable & ~master_q;
  wire is_mast  = spi_enable & master_q;
  wire buf_mode = buffer_mode_enable;
  wire wait_rx  = buffer_wait_receive & ~master_q;
  wire selected = is_slave & ~ss_f_q;
  wire ss_rise  = is_slave & ~ss_f_q & ss_f_d;
  wire ss_kick  = is_mast & ~select_disable_bit & ss_is_input & ~ss_f_q;

  // Slave edges come from the filtered clock, so each phase needs
  // at least two core cycles to be seen at all
  wire s_edge    = selected & (sck_f_d != sck_f_q);
  wire s_lead    = s_edge & (sck_f_d != cpol);
  wire s_trail   = s_edge & (sck_f_d == cpol);
  wire div_hit   = is_mast & busy_q & (div_q == 7'h01);
  wire m_lead    = div_hit & ~edge_q[0];
  wire m_trail   = div_hit & edge_q[0];
  wire lead      = selected ? s_lead : m_lead;
  wire trail     = selected ? s_trail : m_trail;
  wire samp      = cpha ? trail : lead;
  wire setup     = cpha ? lead : trail;
  wire in_bit    = selected ? mosi_f_q : miso_f_q;
  wire m_done    = div_hit & (edge_q == `SBC_EDGES_BYTE - 5'h01);
  wire s_done    = selected & samp & (bit_cnt_q == `SBC_BITS_BYTE - 4'h1);
  wire done      = m_done | s_done;
  wire s_active  = selected & (bit_cnt_q != 4'h0);
  wire fifo_rdy;
  wire rx_room   = buf_mode | ~rx_valid;
  wire start     = is_mast & pend_q & ~busy_q & fifo_rdy & rx_room;
  wire [WIDTH-1:0] sh_shifted = shift_in(sh_q, in_bit, lsb_first);
  wire [WIDTH-1:0] rx_byte    = samp ? sh_shifted : sh_q;

  // --------------------------------------------------------------------------
  // Shifter, transmit buffer and master clock generator
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sh_q       <= `SBC_SHIFT_RST;
      txb_q      <= `SBC_SHIFT_RST;
      txb_full_q <= 1'b0;
      sh_fresh_q <= 1'b0;
      tx_bit_q   <= 1'b0;
      bit_cnt_q  <= 4'h0;
      master_q   <= `SBC_MASTER_RST;
      busy_q     <= 1'b0;
      pend_q     <= 1'b0;
      div_q      <= 7'h00;
      edge_q     <= 5'h00;
      sck_q      <= 1'b0;
    end else begin
      if (master_write) begin
        master_q <= master_wdata;
      end else if (ss_kick) begin
        master_q <= 1'b0;
      end
      if (!spi_enable || ss_kick || ss_rise || (is_slave && ss_f_q)) begin
        bit_cnt_q <= 4'h0;
        busy_q    <= 1'b0;
        edge_q    <= 5'h00;
        sck_q     <= cpol;
      end else begin
        if (samp) begin
          sh_q      <= sh_shifted;
          bit_cnt_q <= (bit_cnt_q == `SBC_BITS_BYTE - 4'h1) ? 4'h0 : bit_cnt_q + 4'h1;
        end
        if (setup) begin
          tx_bit_q <= first_bit(sh_q, lsb_first);
        end
        if (start) begin
          busy_q <= 1'b1;
          pend_q <= 1'b0;
          div_q  <= half_period(prescale, clock_double);
          edge_q <= 5'h00;
          sck_q  <= cpol;
        end else if (div_hit) begin
          sck_q  <= ~sck_q;
          edge_q <= edge_q + 5'h01;
          div_q  <= half_period(prescale, clock_double);
          if (m_done) begin
            busy_q <= 1'b0;
          end
        end else if (busy_q) begin
          div_q <= div_q - 7'h01;
        end
      end
      if (done) begin
        sh_fresh_q <= 1'b0;
        if (buf_mode && txb_full_q) begin
          sh_q       <= txb_q;
          txb_full_q <= 1'b0;
          sh_fresh_q <= 1'b1;
          pend_q     <= is_mast;
        end
      end else if (data_write && spi_enable) begin
        if (!buf_mode) begin
          if (is_slave && s_active) begin
            sh_q <= sh_q;
          end else begin
            sh_q   <= data_wdata;
            pend_q <= is_mast;
          end
        end else if (is_mast && !busy_q && !pend_q && !txb_full_q) begin
          sh_q   <= data_wdata;
          pend_q <= 1'b1;
        end else if (!txb_full_q) begin
          txb_q      <= data_wdata;
          txb_full_q <= 1'b1;
        end
      end else if (buf_mode && wait_rx && is_slave && ss_f_q && txb_full_q
                   && !sh_fresh_q) begin
        sh_q       <= txb_q;
        txb_full_q <= 1'b0;
        sh_fresh_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Flags; a set in the same cycle as a clear wins
  // --------------------------------------------------------------------------
  wire txb_load = (done && buf_mode && txb_full_q) ||
                  (!done && !data_write && buf_mode && wait_rx && is_slave && ss_f_q &&
                   txb_full_q && !sh_fresh_q);
  wire txb_wr   = !done && data_write && spi_enable && buf_mode && !txb_full_q &&
                  !(is_mast && !busy_q && !pend_q);
  wire col_set  = !done && data_write && spi_enable && !buf_mode &&
                  (is_slave ? s_active : (busy_q | pend_q));
  wire rx_pop   = rx_valid & rx_ready;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      if_q        <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      dre_q       <= `SBC_EMPTY_RST;
      rxc_q       <= 1'b0;
      txc_q       <= 1'b0;
      dre_rise_q  <= 1'b0;
      rxc_step_q  <= 1'b0;
      all_sent_q  <= 1'b0;
      all_sent2_q <= 1'b0;
    end else begin
      if ((done && !buf_mode) || ss_kick) begin
        if_q <= 1'b1;
      end else if (clear_transfer_flag) begin
        if_q <= 1'b0;
      end
      if (col_set) begin
        write_collision_flag_q <= 1'b1;
      end else if (clear_write_collision) begin
        write_collision_flag_q <= 1'b0;
      end
      if (txb_load) begin
        dre_q <= 1'b1;
      end else if (txb_wr) begin
        dre_q <= 1'b0;
      end
      dre_rise_q  <= done & buf_mode;
      all_sent_q  <= done & buf_mode & ~txb_full_q;
      rxc_step_q  <= dre_rise_q;
      all_sent2_q <= all_sent_q;
      if (dre_rise_q) begin
        rxc_q <= 1'b1;
      end else if (rx_pop || !rx_valid) begin
        rxc_q <= 1'b0;
      end
      if (rxc_step_q && all_sent2_q) begin
        txc_q <= 1'b1;
      end else if (clear_transfer_complete) begin
        txc_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive queue; master holds off a new byte while it is full, or in normal mode
  // while it holds a byte; a slave cannot be stalled so its byte is dropped
  // --------------------------------------------------------------------------
  sbc_rx_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (2),
    .AW    (1)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (done & rx_room),
    .in_ready  (fifo_rdy),
    .in_data   (rx_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  wire cur_bit = ((bit_cnt_q == 4'h0) && !cpha && !(busy_q && edge_q != 5'h00)) ?
                 first_bit(sh_q, lsb_first) : tx_bit_q;

  assign master_mode            = master_q;
  assign transfer_flag          = if_q;
  assign write_collision_flag   = write_collision_flag_q;
  assign buffer_empty_flag      = dre_q;
  assign receive_complete_flag  = rxc_q;
  assign transfer_complete_flag = txc_q;
  assign irq = (if_q & transfer_irq_enable) |
               (txc_q & transfer_complete_irq_enable) |
               (rxc_q & receive_complete_irq_enable) |
               (dre_q & buf_mode & buffer_empty_irq_enable);
  assign sck_out   = is_mast ? sck_q : cpol;
  assign sck_oe_n  = ~is_mast;
  assign mosi_out  = cur_bit;
  assign mosi_oe_n = ~is_mast;
  assign miso_out  = cur_bit;
  assign miso_oe_n = ~(selected & miso_dir_out);

endmodule

/* File: sbc_core_chk.sv */
// Checker of the buffered SPI core, watching only the top module's ports
// Assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps

module sbc_core_chk (
  input logic ref_clk,
  input logic reset_n,
  input logic spi_enable,
  input logic master_mode,
  input logic buffer_mode_enable,
  input logic buffer_wait_receive,
  input logic select_disable_bit,
  input logic ss_is_input,
  input logic miso_dir_out,
  input logic transfer_irq_enable,
  input logic transfer_complete_irq_enable,
  input logic data_write,
  input logic transfer_flag,
  input logic buffer_empty_flag,
  input logic receive_complete_flag,
  input logic transfer_complete_flag,
  input logic irq,
  input logic sck_oe_n,
  input logic miso_oe_n,
  input logic ss_n_in
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------------------
  // Buffer flag steps
  // ---------------------------------------------------------------------------
  sequence s_empty_rise;
    $rose(buffer_empty_flag) && buffer_mode_enable && !buffer_wait_receive;
  endsequence
  sequence s_tc_rise;
    $rose(transfer_complete_flag) && buffer_mode_enable;
  endsequence
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  // Five cycles cover the select synchroniser
  a_miso_released:
    assert property ((!master_mode && spi_enable && ss_n_in)[*5] |-> miso_oe_n)
    else $error("miso driven while deselected");
  a_miso_dir_gate:
    assert property (!miso_dir_out && !$past(miso_dir_out) |-> miso_oe_n)
    else $error("miso driven with port direction input");
  a_sck_slave_in:
    assert property ((!master_mode)[*2] |-> sck_oe_n)
    else $error("sck driven in slave mode");
  a_empty_on_write:
    assert property (buffer_mode_enable && !master_mode && !buffer_wait_receive && data_write
      |-> ##[1:2] !buffer_empty_flag)
    else $error("buffer empty flag kept after buffer write");
  a_rxc_after_empty:
    assert property (s_empty_rise |=> receive_complete_flag)
    else $error("receive complete late after buffer empty");
  a_tc_after_rxc:
    assert property (s_tc_rise |-> $past(receive_complete_flag))
    else $error("transfer complete before receive complete");
  a_tc_needs_empty:
    assert property (s_tc_rise |-> buffer_empty_flag)
    else $error("transfer complete with buffer full");
  a_irq_follows:
    assert property ((transfer_flag && transfer_irq_enable)
      || (transfer_complete_flag && transfer_complete_irq_enable) |-> irq)
    else $error("request missing while flag enabled");
  a_master_lost:
    assert property ((spi_enable && !select_disable_bit && ss_is_input && !ss_n_in)[*6]
      |-> !master_mode)
    else $error("master kept with select low");
  a_lost_flag:
    assert property ($fell(master_mode) && !ss_n_in && !select_disable_bit
      |-> ##[0:2] transfer_flag)
    else $error("no transfer flag on lost master");
endmodule

bind sbc_core sbc_core_chk sbc_core_chk_i (.*);

/* File: sbc_remote.sv */
// Remote SPI master model: mode 0, MSB first, 160 ns link clock in frames
// Assumes the core's MISO pair; no pull on MISO, so a released line inverts
`timescale 1ns/1ps

module sbc_remote (
  input  logic miso_out,
  input  logic miso_oe_n,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  logic miso_last = 1'b0;
  logic miso_pin;

  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  always @(miso_out) if (!miso_oe_n) miso_last = miso_out;
  assign miso_pin = miso_oe_n ? ~miso_last : miso_out;

  // ---------------------------------------------------------------------------
  // Frame; short frames end early to abort, clock stands low outside
  // ---------------------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    ss_n = 1'b0;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi = tx[i];
      #80 sck = 1'b1;
      rx[i] = miso_pin;
      #80 sck = 1'b0;
    end
    // Long hold so the last edge clears the synchroniser before select rises
    #160 ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

/* File: sbc_core_bench.sv */
// Self-checking bench of the buffered SPI core with a remote master model
// Assumes MISO looped to MOSI while the core is master
`timescale 1ns/1ps

module sbc_core_bench;
  logic ref_clk, reset_n, spi_enable, master_write, master_wdata, master_mode;
  logic buffer_mode_enable, buffer_wait_receive, select_disable_bit, ss_is_input;
  logic miso_dir_out, lsb_first, clock_double, transfer_irq_enable, rx_ready;
  logic transfer_complete_irq_enable, receive_complete_irq_enable, buffer_empty_irq_enable;
  logic clear_transfer_flag, clear_write_collision, clear_transfer_complete, data_write;
  logic rx_valid, transfer_flag, write_collision_flag, buffer_empty_flag, irq;
  logic receive_complete_flag, transfer_complete_flag, sck_in, sck_out, sck_oe_n;
  logic mosi_in, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n, ss_n_in;
  logic [1:0] clock_mode, prescale;
  logic [7:0] data_wdata, rx_data, rb;
  wire  [7:0] st = {master_mode, irq, miso_oe_n, transfer_flag, write_collision_flag,
                    buffer_empty_flag, receive_complete_flag, transfer_complete_flag};
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  sbc_core sbc_core_i (.*);
  sbc_remote sbc_remote_i (.miso_out(miso_out), .miso_oe_n(miso_oe_n), .sck(sck_in),
                           .ss_n(ss_n_in), .mosi(mosi_in));
  assign miso_in = mosi_out;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic close_out;
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
      err_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    data_write <= 1'b1;
    data_wdata <= d;
    @(posedge ref_clk);
    data_write <= 1'b0;
    idle(2);
  endtask
  task automatic pop;
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    @(posedge ref_clk);
    rx_ready <= 1'b0;
    idle(2);
  endtask
  task automatic clr;
    @(posedge ref_clk);
    {clear_transfer_flag, clear_write_collision, clear_transfer_complete} <= 3'h7;
    @(posedge ref_clk);
    {clear_transfer_flag, clear_write_collision, clear_transfer_complete} <= 3'h0;
    idle(1);
  endtask
  // Bounded wait on one status bit
  task automatic wait_f(input int b);
    for (int k = 0; k < 600 && st[b] !== 1'b1; k++) idle(1);
    idle(4);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {reset_n, spi_enable, master_write, master_wdata, buffer_mode_enable, buffer_wait_receive,
     lsb_first, clock_mode, clock_double, transfer_complete_irq_enable, rx_ready,
     receive_complete_irq_enable, buffer_empty_irq_enable, clear_transfer_flag,
     clear_write_collision, clear_transfer_complete, data_write, data_wdata} = '0;
    {select_disable_bit, ss_is_input, miso_dir_out, transfer_irq_enable} = 4'hF;
    prescale = 2'h1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    spi_enable <= 1'b1;
    idle(4);
    chk(st, 8'h24);
    chk({6'h00, sck_oe_n, mosi_oe_n}, 8'h03);
    wr(8'hA5);
    sbc_remote_i.xfer(8'h3C, 8, rb);
    chk(rb, 8'hA5);
    idle(8);
    chk(st, 8'h74, 8'hF4);
    chk(rx_data, 8'h3C);
    sbc_remote_i.xfer(8'hC3, 8, rb);
    idle(8);
    chk(rx_data, 8'h3C);
    pop;
    chk({7'h00, rx_valid}, 8'h00);
    clr;
    wr(8'h11);
    fork
      sbc_remote_i.xfer(8'h5E, 8, rb);
      begin #400; wr(8'h22); end
    join
    chk(rb, 8'h11);
    idle(8);
    chk(st, 8'h18, 8'h18);
    chk(rx_data, 8'h5E);
    pop;
    clr;
    miso_dir_out <= 1'b0;
    wr(8'h77);
    sbc_remote_i.xfer(8'hF0, 4, rb);
    idle(8);
    chk({6'h00, rx_valid, transfer_flag}, 8'h00);
    sbc_remote_i.xfer(8'h0F, 8, rb);
    idle(8);
    chk(rx_data, 8'h0F);
    chk(st, 8'h30, 8'h30);
    pop;
    clr;
    miso_dir_out <= 1'b1;
    buffer_mode_enable <= 1'b1;
    transfer_complete_irq_enable <= 1'b1;
    receive_complete_irq_enable <= 1'b1;
    wr(8'h43);
    chk(st, 8'h00, 8'h04);
    wr(8'h45);
    sbc_remote_i.xfer(8'h01, 8, rb);
    idle(8);
    chk(st, 8'h06, 8'h07);
    sbc_remote_i.xfer(8'h02, 8, rb);
    chk(rb, 8'h43);
    idle(8);
    chk(st, 8'h47, 8'h47);
    chk(rx_data, 8'h01);
    pop;
    chk(rx_data, 8'h02);
    pop;
    clr;
    buffer_wait_receive <= 1'b1;
    wr(8'h44);
    wr(8'h46);
    chk(st, 8'h00, 8'h04);
    sbc_remote_i.xfer(8'h03, 8, rb);
    chk(rb, 8'h44);
    sbc_remote_i.xfer(8'h04, 8, rb);
    chk(rb, 8'h46);
    idle(8);
    chk(rx_data, 8'h03);
    pop;
    chk(rx_data, 8'h04);
    pop;
    clr;
    {buffer_mode_enable, buffer_wait_receive} <= 2'h0;
    lsb_first <= 1'b1;
    clock_mode <= 2'h3;
    master_wdata <= 1'b1;
    master_write <= 1'b1;
    idle(1);
    master_write <= 1'b0;
    idle(2);
    chk(st, 8'h80, 8'h80);
    wr(8'h5A);
    wait_f(4);
    chk(rx_data, 8'h5A);
    chk(st, 8'h90, 8'h90);
    chk({7'h00, sck_out}, 8'h01);
    pop;
    clr;
    clock_mode <= 2'h0;
    wr(8'hA1);
    idle(30);
    wr(8'hB2);
    wait_f(4);
    chk(st, 8'h88, 8'h88);
    pop;
    clr;
    wait_f(4);
    chk(st, 8'h90, 8'h90);
    pop;
    clr;
    {buffer_mode_enable, buffer_wait_receive} <= 2'h3;
    wr(8'h61);
    chk(st, 8'h84, 8'h84);
    wr(8'h62);
    chk(st, 8'h00, 8'h04);
    wait_f(0);
    chk(rx_data, 8'h61);
    pop;
    chk(rx_data, 8'h62);
    pop;
    buffer_mode_enable <= 1'b0;
    select_disable_bit <= 1'b0;
    clr;
    sbc_remote_i.ss_n = 1'b0;
    idle(10);
    chk(st, 8'h10, 8'h90);
    sbc_remote_i.ss_n = 1'b1;
    close_out();
  end
endmodule
